// ### hdl/fpcd_host_ctrl.sv
// Host controller issuing protection and query command sequences to a flash.
// Assumes one request at a time on the user side and a flash on the pins.
//
// Behaviour
// - Lock register: enter 40, program A0, exit 90/00
// - Non-volatile bits: enter C0, program, erase 80/30
// - Freeze: enter 50, set A0/00, read, exit
// - Volatile bits: enter E0, set 00, clear 01
// - Host issues only defined command codes
// - Query entry: 98 at 55 word, AA byte
// - Query mode left only by reset command
`timescale 1ns/1ps
`default_nettype none
module fpcd_host_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // User request port
   input wire logic reqValid,
   input wire fpcd_pkg::fpcd_req_t req,
   input wire logic byteMode,
   output logic busy,
   output logic done,
   output logic err,
   output logic [fpcd_pkg::DATA_W-1:0] rdData,
   output fpcd_pkg::fpcd_mode_t mode,
   // Flash pins
   output fpcd_pkg::fpcd_pins_t pins,
   input wire logic [fpcd_pkg::DATA_W-1:0] dqIn
);
   import fpcd_pkg::*;

   // Whole module state
   typedef struct packed {
      fpcd_state_t state;
      fpcd_mode_t mode;
      fpcd_req_t req;
      logic byteM;
      logic [1:0] step;
      logic [CNT_W-1:0] cnt;
      fpcd_pins_t pins;
      logic [DATA_W-1:0] dqS1;
      logic [DATA_W-1:0] dqS2;
      logic [DATA_W-1:0] dqS3;
      logic [DATA_W-1:0] rdData;
      logic busy;
      logic done;
      logic err;
   } fpcd_regs_t;

   fpcd_regs_t s_reg; // Registered state
   fpcd_regs_t s_next; // Next state
   fpcd_step_t cur; // Bus cycle now being run

   // Idle pins: all strobes high, bus released
   localparam fpcd_pins_t PINS_IDLE = '{addr: '0, dq: '0, dqOe: 1'b0,
      ceN: 1'b1, weN: 1'b1, oeN: 1'b1};

   // Zero-extend a short constant address
   function automatic logic [ADDR_W-1:0] ext(input logic [11:0] a);
      return {{(ADDR_W-12){1'b0}}, a};
   endfunction

   // Third code of each mode entry sequence
   function automatic logic [7:0] entryCode(input fpcd_op_t op);
      case (op)
         OP_LOCK_ENTER: return C_LOCK;
         OP_NVB_ENTER: return C_NVB;
         OP_FRZ_ENTER: return C_FRZ;
         default: return C_VOL;
      endcase
   endfunction

   // Bus cycle number idx of a command sequence
   function automatic fpcd_step_t stepOf(input fpcd_req_t r, input logic [1:0] idx,
         input logic bm);
      fpcd_step_t t;
      t = '{isRead: 1'b0, last: 1'b0, addr: '0, dq: C_ZERO};
      case (r.op)
         OP_LOCK_ENTER, OP_NVB_ENTER, OP_FRZ_ENTER, OP_VOL_ENTER: begin
            // Two unlock writes, then the mode code
            t.addr = ext((idx == 2'd1) ? (bm ? A_B2 : A_W2) : (bm ? A_B1 : A_W1));
            t.dq = (idx == 2'd0) ? C_UNLK1 : (idx == 2'd1) ? C_UNLK2 : entryCode(r.op);
            t.last = (idx == 2'd2);
         end
         OP_LOCK_PROG: begin
            // Program opener, then the new lock value
            t.dq = (idx == 2'd0) ? C_PROG : r.data;
            t.last = (idx != 2'd0);
         end
         OP_NVB_PROG, OP_VOL_SET, OP_VOL_CLR, OP_FRZ_SET: begin
            // Opener, then 00 or 01 at the sector address; freeze set writes 00 at address zero
            t.addr = (idx == 2'd0 || r.op == OP_FRZ_SET) ? '0 : r.addr;
            t.dq = (idx == 2'd0) ? C_PROG : (r.op == OP_VOL_CLR) ? C_ONE : C_ZERO;
            t.last = (idx != 2'd0);
         end
         OP_NVB_ERASE: begin
            // Erase opener, confirm at address zero
            t.dq = (idx == 2'd0) ? C_ERS : C_ERSC;
            t.last = (idx != 2'd0);
         end
         OP_MODE_EXIT: begin
            t.dq = (idx == 2'd0) ? C_EXIT : C_ZERO;
            t.last = (idx != 2'd0);
         end
         OP_STATUS_READ, OP_CFI_READ: begin
            // Single read; the flash halves the query address in byte mode
            t.isRead = 1'b1;
            t.addr = r.addr;
            t.last = 1'b1;
         end
         OP_CFI_ENTER: begin
            t.addr = ext(bm ? A_CFIB : A_CFIW);
            t.dq = C_CFI;
            t.last = 1'b1;
         end
         OP_CFI_RESET: begin
            t.dq = C_RESET;
            t.last = 1'b1;
         end
         default: t.last = 1'b1;
      endcase
      return t;
   endfunction

   // Only sequences that are defined in the present mode are sent
   function automatic logic opAllowed(input fpcd_op_t op, input fpcd_mode_t m);
      case (op)
         OP_LOCK_ENTER, OP_NVB_ENTER, OP_FRZ_ENTER, OP_VOL_ENTER,
         OP_CFI_ENTER: return m == MD_ARRAY;
         OP_LOCK_PROG: return m == MD_LOCK;
         OP_NVB_PROG, OP_NVB_ERASE: return m == MD_NVB;
         OP_FRZ_SET: return m == MD_FRZ;
         OP_VOL_SET, OP_VOL_CLR: return m == MD_VOL;
         OP_MODE_EXIT, OP_STATUS_READ: return m inside {MD_LOCK, MD_NVB, MD_FRZ, MD_VOL};
         OP_CFI_READ, OP_CFI_RESET: return m == MD_CFI;
         default: return 1'b0;
      endcase
   endfunction

   // Mode after a finished sequence
   function automatic fpcd_mode_t modeAfter(input fpcd_op_t op, input fpcd_mode_t m);
      case (op)
         OP_LOCK_ENTER: return MD_LOCK;
         OP_NVB_ENTER: return MD_NVB;
         OP_FRZ_ENTER: return MD_FRZ;
         OP_VOL_ENTER: return MD_VOL;
         OP_CFI_ENTER: return MD_CFI;
         OP_MODE_EXIT, OP_CFI_RESET: return MD_ARRAY;
         default: return m;
      endcase
   endfunction

   assign cur = stepOf(s_reg.req, s_reg.step, s_reg.byteM);

   // Next-state logic for the sequencer
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      // Three-stage input sampler for the data bus
      s_next.dqS1 = dqIn;
      s_next.dqS2 = s_reg.dqS1;
      s_next.dqS3 = s_reg.dqS2;
      case (s_reg.state)
         ST_IDLE: begin
            if (reqValid) begin
               s_next.req = req;
               s_next.byteM = byteMode;
               s_next.step = 2'd0;
               if (opAllowed(req.op, s_reg.mode)) begin
                  s_next.state = ST_SETUP;
                  s_next.busy = 1'b1;
               end else begin
                  // Undefined in this mode: refused, nothing on the bus
                  s_next.done = 1'b1;
                  s_next.err = 1'b1;
               end
            end
         end
         ST_SETUP: begin
            // Address, data and chip enable settle before the strobe
            s_next.pins.addr = cur.addr;
            s_next.pins.dq = {{(DATA_W-8){1'b0}}, cur.dq};
            s_next.pins.dqOe = ~cur.isRead;
            s_next.pins.ceN = 1'b0;
            s_next.state = ST_STROBE;
            s_next.cnt = '0;
         end
         ST_STROBE: begin
            // Write pulse or output enable for the required time
            s_next.pins.weN = cur.isRead;
            s_next.pins.oeN = ~cur.isRead;
            s_next.cnt = s_reg.cnt + 1'b1;
            if (!cur.isRead && s_reg.cnt == CNT_W'(CYC_WP)) begin
               s_next.pins.weN = 1'b1;
               s_next.state = ST_HOLD;
               s_next.cnt = '0;
            end else if (cur.isRead && s_reg.cnt == CNT_W'(CYC_ACC + SYNC_LAT)) begin
               s_next.state = ST_CAPT;
            end
         end
         ST_CAPT: begin
            // Take the bus value once two sampled copies agree
            if (s_reg.dqS2 == s_reg.dqS3) begin
               s_next.rdData = s_reg.dqS3;
               s_next.pins.oeN = 1'b1;
               s_next.state = ST_HOLD;
               s_next.cnt = '0;
            end
         end
         ST_HOLD: begin
            // Recovery gap with strobes high before the next bus cycle
            s_next.pins.ceN = 1'b1;
            s_next.pins.dqOe = 1'b0;
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == CNT_W'(CYC_GAP)) begin
               if (cur.last) begin
                  s_next.state = ST_IDLE;
                  s_next.busy = 1'b0;
                  s_next.done = 1'b1;
                  s_next.err = 1'b0;
                  s_next.mode = modeAfter(s_reg.req.op, s_reg.mode);
               end else begin
                  s_next.step = s_reg.step + 2'd1;
                  s_next.state = ST_SETUP;
               end
            end
         end
         default: begin
            s_next.state = ST_IDLE;
            s_next.pins = PINS_IDLE;
            s_next.busy = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '{state: ST_IDLE, mode: MD_ARRAY, req: '0, byteM: 1'b0, step: 2'd0,
            cnt: '0, pins: PINS_IDLE, dqS1: '0, dqS2: '0, dqS3: '0, rdData: '0,
            busy: 1'b0, done: 1'b0, err: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign busy = s_reg.busy;
   assign done = s_reg.done;
   assign err = s_reg.err;
   assign rdData = s_reg.rdData;
   assign mode = s_reg.mode;
   assign pins = s_reg.pins;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Lock entry's third write carries 40 at the first unlock address
   chk_lock_entry_code: assert property (
      (s_reg.state == ST_STROBE && s_reg.req.op == OP_LOCK_ENTER && s_reg.step == 2'd2)
      |-> s_reg.pins.dq[7:0] == 8'h40
      && s_reg.pins.addr[11:0] == (s_reg.byteM ? 12'hAAA : 12'h555))
      else $error("lock entry code or address wrong");
   // Non-volatile erase confirm is 30 at address zero
   chk_nvb_erase_confirm: assert property (
      (s_reg.state == ST_STROBE && s_reg.req.op == OP_NVB_ERASE && s_reg.step == 2'd1)
      |-> s_reg.pins.dq[7:0] == 8'h30 && s_reg.pins.addr == '0)
      else $error("erase confirm wrong");
   // Freeze set ends in 00 and leaves the freeze mode in place
   chk_freeze_set: assert property (
      (s_reg.done && !s_reg.err && s_reg.req.op == OP_FRZ_SET)
      |-> s_reg.mode == MD_FRZ && $past(s_reg.pins.dq[7:0], CYC_GAP + 2) == 8'h00)
      else $error("freeze set sequence wrong");
   // Volatile clear writes 01 at the sector address
   chk_vol_clear: assert property (
      (s_reg.state == ST_STROBE && s_reg.req.op == OP_VOL_CLR && s_reg.step == 2'd1)
      |-> s_reg.pins.dq[7:0] == 8'h01 && s_reg.pins.addr == s_reg.req.addr)
      else $error("volatile clear data wrong");
   // A refused request never touches the bus
   chk_refused_quiet: assert property (
      (s_reg.state == ST_IDLE && reqValid && !opAllowed(req.op, s_reg.mode))
      |=> s_reg.err && s_reg.done && s_reg.pins.ceN ##1 s_reg.pins.ceN)
      else $error("refused request reached the bus");
   // Query entry writes 98 at 55 in word mode or AA in byte mode
   chk_query_entry: assert property (
      (s_reg.state == ST_STROBE && s_reg.req.op == OP_CFI_ENTER && !s_reg.pins.weN)
      |-> s_reg.pins.dq[7:0] == 8'h98
      && s_reg.pins.addr[11:0] == (s_reg.byteM ? 12'h0AA : 12'h055))
      else $error("query entry wrong");
   // Query mode is left only after the reset command
   chk_query_leave: assert property (
      ($past(s_reg.mode) == MD_CFI && s_reg.mode != MD_CFI)
      |-> s_reg.mode == MD_ARRAY && s_reg.req.op == OP_CFI_RESET && s_reg.done)
      else $error("query mode left without reset");
endmodule
`default_nettype wire

// ### hdl/fpcd_pkg.sv
// Package for the flash protection and query command host controller.
// Assumes a 25 MHz system clock and an asynchronous parallel flash on the pins.
package fpcd_pkg;
   // Clock rate and bus widths
   localparam int CLK_MHZ = 25;
   localparam int ADDR_W = 25;
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;
   // Bus cycle times in ns; the flash timing is not given here, so plain values
   localparam int T_WP_NS = 35;
   localparam int T_ACC_NS = 70;
   localparam int T_GAP_NS = 20;
   // Least times round up to whole cycles, never below one
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int CYC_WP = ns2cyc(T_WP_NS);
   localparam int CYC_ACC = ns2cyc(T_ACC_NS);
   localparam int CYC_GAP = ns2cyc(T_GAP_NS);
   localparam int SYNC_LAT = 3;
   // Command codes on the data bus
   localparam logic [7:0] C_UNLK1 = 8'hAA;
   localparam logic [7:0] C_UNLK2 = 8'h55;
   localparam logic [7:0] C_LOCK = 8'h40;
   localparam logic [7:0] C_NVB = 8'hC0;
   localparam logic [7:0] C_FRZ = 8'h50;
   localparam logic [7:0] C_VOL = 8'hE0;
   localparam logic [7:0] C_PROG = 8'hA0;
   localparam logic [7:0] C_ERS = 8'h80;
   localparam logic [7:0] C_ERSC = 8'h30;
   localparam logic [7:0] C_EXIT = 8'h90;
   localparam logic [7:0] C_ZERO = 8'h00;
   localparam logic [7:0] C_ONE = 8'h01;
   localparam logic [7:0] C_CFI = 8'h98;
   localparam logic [7:0] C_RESET = 8'hF0;
   // Unlock and query addresses, word and byte addressing
   localparam logic [11:0] A_W1 = 12'h555;
   localparam logic [11:0] A_W2 = 12'h2AA;
   localparam logic [11:0] A_B1 = 12'hAAA;
   localparam logic [11:0] A_B2 = 12'h555;
   localparam logic [11:0] A_CFIW = 12'h055;
   localparam logic [11:0] A_CFIB = 12'h0AA;
   // Commands the user side may ask for
   typedef enum logic [3:0] {
      OP_LOCK_ENTER, OP_LOCK_PROG, OP_NVB_ENTER, OP_NVB_PROG, OP_NVB_ERASE,
      OP_FRZ_ENTER, OP_FRZ_SET, OP_VOL_ENTER, OP_VOL_SET, OP_VOL_CLR,
      OP_MODE_EXIT, OP_STATUS_READ, OP_CFI_ENTER, OP_CFI_READ, OP_CFI_RESET
   } fpcd_op_t;
   // Command mode the flash is believed to be in
   typedef enum logic [5:0] {
      MD_ARRAY = 6'b00_0001, MD_LOCK = 6'b00_0010, MD_NVB = 6'b00_0100,
      MD_FRZ = 6'b00_1000, MD_VOL = 6'b01_0000, MD_CFI = 6'b10_0000
   } fpcd_mode_t;
   // Bus cycle sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001, ST_SETUP = 5'b0_0010, ST_STROBE = 5'b0_0100,
      ST_CAPT = 5'b0_1000, ST_HOLD = 5'b1_0000
   } fpcd_state_t;
   // User request
   typedef struct packed {
      fpcd_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } fpcd_req_t;
   // Flash pins driven by the host
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic dqOe;
      logic ceN;
      logic weN;
      logic oeN;
   } fpcd_pins_t;
   // One bus cycle of a command sequence
   typedef struct packed {
      logic isRead;
      logic last;
      logic [ADDR_W-1:0] addr;
      logic [7:0] dq;
   } fpcd_step_t;
endpackage

// ### verif/fpcd_flash_model.sv
// Behavioural flash answering protection and query command sequences.
// Assumes the controller's pins and a byte-mode strap shared with the bench.
`timescale 1ns/1ps
`default_nettype none
module fpcd_flash_model #(
   parameter logic [15:0] SET_ID = 16'h0A0B // Arbitrary command-set code
) (
   // Host pins and straps
   input wire fpcd_pkg::fpcd_pins_t pins,
   input wire logic byteMode,
   input wire logic slow,
   // Data back to the host
   output logic [15:0] dqOut
);
   import fpcd_pkg::*;
   fpcd_mode_t md = MD_ARRAY; // Current command mode
   logic [7:0] pre = 8'h00; // First byte of a two-cycle command
   logic [7:0] lockReg = 8'h00;
   logic [15:0] nvb = '1; // Bit set means unlocked
   logic [15:0] vol = '1;
   logic frz = 1'b1;
   logic [15:0] last = 16'h0000;
   logic [15:0] rv;
   logic [7:0] d;
   logic [3:0] sec;
   int un = 0; // Unlock cycles seen so far
   int wa;
   wire logic lateEn; // Access time met, for the slow flash
   assign sec = pins.addr[3:0];
   // Commands are latched on the rising write strobe
   always @(posedge pins.weN) begin
      if (!pins.ceN) begin
         d = pins.dq[7:0];
         if (md == MD_CFI) begin
            if (d == C_RESET) md = MD_ARRAY;
         end else if (md == MD_ARRAY) begin
            if (d == C_CFI && pins.addr[11:0] == (byteMode ? A_CFIB : A_CFIW)) md = MD_CFI;
            else if (un == 2) begin
               case (d)
                  C_LOCK: md = MD_LOCK;
                  C_NVB: md = MD_NVB;
                  C_FRZ: md = MD_FRZ;
                  C_VOL: md = MD_VOL;
                  default: md = MD_ARRAY;
               endcase
            end
            un = (d == C_UNLK1) ? 1 : (un == 1 && d == C_UNLK2) ? 2 : 0;
         end else if (pre == C_PROG) begin
            case (md)
               MD_LOCK: lockReg = d;
               MD_NVB: nvb[sec] = (d == C_ZERO) ? 1'b0 : nvb[sec];
               MD_FRZ: frz = (d == C_ZERO) ? 1'b0 : frz;
               default: vol[sec] = d[0];
            endcase
            pre = 8'h00;
         end else if (pre == C_ERS && d == C_ERSC) begin
            nvb = '1;
            pre = 8'h00;
         end else if (pre == C_EXIT && d == C_ZERO) begin
            md = MD_ARRAY;
            pre = 8'h00;
         end else pre = d;
      end
   end
   // Read value for the current mode
   always @* begin
      wa = byteMode ? int'(pins.addr >> 1) : int'(pins.addr);
      case (md)
         MD_LOCK: rv = {8'h00, lockReg};
         MD_NVB: rv = {15'h0000, nvb[sec]};
         MD_FRZ: rv = {15'h0000, frz};
         MD_VOL: rv = {15'h0000, vol[sec]};
         MD_CFI: rv = wa == 'h10 ? 16'h0051 : wa == 'h11 ? 16'h0052 :
            wa == 'h12 ? 16'h0059 :
            wa == 'h13 ? {8'h00, SET_ID[7:0]} : wa == 'h14 ? {8'h00, SET_ID[15:8]} :
            wa == 'h15 ? 16'h0040 : 16'h0000;
         default: rv = pins.addr[15:0] ^ 16'h5A5A;
      endcase
   end
   // Released bus shows the inverse of the last word, never a stale copy
   always @(posedge pins.oeN) last = rv;
   // Inertial delay: a slow read shows late but vanishes at once on release
   assign #60 lateEn = !pins.ceN && !pins.oeN;
   always @* begin
      if (!pins.ceN && !pins.oeN && (!slow || lateEn)) dqOut = rv;
      else dqOut = ~last;
   end
endmodule
`default_nettype wire

// ### verif/flash_protect_cfi_decoder_tb.sv
// Self-checking bench for the flash protection and query host controller.
// Assumes the flash model beside it; a reference model predicts every result.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module flash_protect_cfi_decoder_tb;
   import fpcd_pkg::*;
   localparam logic [15:0] SET_ID = 16'h0A0B; // Arbitrary command-set code
   logic clk = 0, rst = 1, reqValid = 0, byteMode = 0, bmSel = 0, slow = 0;
   fpcd_req_t req = '0;
   logic busy, done, err;
   logic [DATA_W-1:0] rdData, dqIn;
   fpcd_mode_t mode;
   fpcd_pins_t pins;
   int n_mismatch = 0, n_checks = 0, seed = 32'ha0cf_baab, s0;
   // Reference state; a set bit means unlocked
   fpcd_mode_t em = MD_ARRAY;
   logic [7:0] lk = 8'h00;
   logic [15:0] nv = '1, vo = '1, erd = 16'h0000;
   logic fz = 1'b1;
   fpcd_op_t ops[29] = '{OP_STATUS_READ, OP_LOCK_ENTER, OP_LOCK_PROG, OP_STATUS_READ,
      OP_NVB_ENTER, OP_MODE_EXIT, OP_NVB_ENTER, OP_NVB_PROG, OP_STATUS_READ, OP_NVB_ERASE,
      OP_STATUS_READ, OP_MODE_EXIT, OP_FRZ_ENTER, OP_STATUS_READ, OP_FRZ_SET, OP_STATUS_READ,
      OP_MODE_EXIT, OP_VOL_ENTER, OP_VOL_SET, OP_STATUS_READ, OP_VOL_CLR, OP_STATUS_READ,
      OP_MODE_EXIT, OP_CFI_READ, OP_CFI_ENTER, OP_VOL_ENTER, OP_MODE_EXIT, OP_CFI_RESET,
      OP_CFI_RESET};
   always #20 clk = ~clk;
   fpcd_host_ctrl i_dut (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
      .byteMode(byteMode), .busy(busy), .done(done), .err(err), .rdData(rdData),
      .mode(mode), .pins(pins), .dqIn(dqIn));
   fpcd_flash_model #(.SET_ID(SET_ID)) i_flash (.pins(pins), .byteMode(byteMode),
      .slow(slow), .dqOut(dqIn));
   // Verdict and end of run
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Query table as the reference sees it
   function automatic logic [15:0] cfi(input int w);
      case (w)
         'h10: return 16'h0051;
         'h11: return 16'h0052;
         'h12: return 16'h0059;
         'h13: return {8'h00, SET_ID[7:0]};
         'h14: return {8'h00, SET_ID[15:8]};
         'h15: return 16'h0040;
         default: return 16'h0000;
      endcase
   endfunction
   // One request: predict, issue, wait for done, compare
   task automatic run(input fpcd_op_t op, input int a, input logic [7:0] d);
      logic ok;
      int k;
      case (op)
         OP_LOCK_ENTER, OP_NVB_ENTER, OP_FRZ_ENTER, OP_VOL_ENTER,
         OP_CFI_ENTER: ok = em == MD_ARRAY;
         OP_LOCK_PROG: ok = em == MD_LOCK;
         OP_NVB_PROG, OP_NVB_ERASE: ok = em == MD_NVB;
         OP_FRZ_SET: ok = em == MD_FRZ;
         OP_VOL_SET, OP_VOL_CLR: ok = em == MD_VOL;
         OP_CFI_READ, OP_CFI_RESET: ok = em == MD_CFI;
         default: ok = em != MD_ARRAY && em != MD_CFI;
      endcase
      if (ok) begin
         case (op)
            OP_LOCK_ENTER: em = MD_LOCK;
            OP_NVB_ENTER: em = MD_NVB;
            OP_FRZ_ENTER: em = MD_FRZ;
            OP_VOL_ENTER: em = MD_VOL;
            OP_CFI_ENTER: em = MD_CFI;
            OP_LOCK_PROG: lk = d;
            OP_NVB_PROG: nv[a % 16] = 1'b0;
            OP_NVB_ERASE: nv = '1;
            OP_FRZ_SET: fz = 1'b0;
            OP_VOL_SET: vo[a % 16] = 1'b0;
            OP_VOL_CLR: vo[a % 16] = 1'b1;
            OP_STATUS_READ: erd = em == MD_LOCK ? {8'h00, lk} :
               em == MD_NVB ? {15'h0000, nv[a % 16]} :
               em == MD_FRZ ? {15'h0000, fz} : {15'h0000, vo[a % 16]};
            OP_CFI_READ: erd = cfi(bmSel ? a / 2 : a);
            default: em = MD_ARRAY;
         endcase
      end
      @(posedge clk);
      reqValid <= 1'b1;
      byteMode <= bmSel;
      req <= '{op: op, addr: ADDR_W'(a), data: d};
      @(posedge clk);
      reqValid <= 1'b0;
      // Accepted work shows busy at once; a refusal pulses done in this same cycle
      #1;
      `CHK(busy, ok)
      for (k = 0; k < 400; k++) begin
         if (done === 1'b1) break;
         @(posedge clk);
         #1;
      end
      if (k == 400) begin
         // Hung request: counted, then straight to the verdict
         n_mismatch++;
         summarize();
      end else begin
         `CHK(err, !ok)
         `CHK(mode, em)
         `CHK(busy, 1'b0)
         `CHK(rdData, erd)
      end
   endtask
   // Main sequence: both addressing modes, prompt and slow flash
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(mode, MD_ARRAY)
      `CHK(pins.ceN, 1'b1)
      for (int p = 0; p < 2; p++) begin
         bmSel = p[0];
         slow = p[0];
         s0 = {$random(seed)} % 65536;
         foreach (ops[i]) run(ops[i], s0 ^ ({$random(seed)} % 2), 8'($random(seed)));
         run(OP_CFI_ENTER, 0, 8'h00);
         for (int w = 'h10; w <= 'h1A; w++) run(OP_CFI_READ, bmSel ? 2 * w : w, 8'h00);
         run(OP_CFI_RESET, 0, 8'h00);
      end
      summarize();
   end
endmodule
`default_nettype wire
